// File: core/mqf_pkg.sv
// mqf_pkg: constants, register map and carrier types of the multi-queue fifo core
// assumes: shared by the core and by whoever drives its wishbone slave

package mqf_pkg;

  // ----------------------------------------------------------------------
  // pool geometry
  // ----------------------------------------------------------------------
  localparam int MQF_MAX_Q = 4;          // most queues in one pool
  localparam int MQF_DEF_BLOCKS = 64;    // blocks in the smallest density option
  localparam int MQF_BLK_HALVES = 1024;  // one block in 9-bit halves (same as 512 x 18)
  localparam int MQF_BLK_SH = 10;        // log2 of the halves in one block
  localparam int MQF_HALF_W = 9;         // width of one half word
  localparam int MQF_WORD_W = 18;        // width of a full port word

  // ----------------------------------------------------------------------
  // wishbone register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] MQF_GRP_CTRL = 4'h0;  // 0x00 control, 0x04 status
  localparam logic [3:0] MQF_GRP_QSIZE = 4'h1; // 0x10 + 4*q staged queue size in blocks
  localparam logic [3:0] MQF_GRP_AFT = 4'h2;   // 0x20 + 4*q almost-full distance
  localparam logic [3:0] MQF_GRP_AET = 4'h3;   // 0x30 + 4*q almost-empty level
  localparam logic [3:0] MQF_GRP_LVL = 4'h4;   // 0x40 + 4*q fill level, read only
  localparam logic [1:0] MQF_IDX_CTRL = 2'h0;
  localparam logic [1:0] MQF_IDX_STAT = 2'h1;

  // ----------------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------------
  localparam int MQF_CTRL_WWIDE = 0; // write port is 18 bits
  localparam int MQF_CTRL_RWIDE = 1; // read port is 18 bits
  localparam int MQF_CTRL_QCNT = 2;  // two bits: queue count minus one
  localparam int MQF_CTRL_MRST = 8;  // write 1: master reset, commit setup
  localparam int MQF_CTRL_PRST = 9;  // write 1: partial reset of the shared queue

  // ----------------------------------------------------------------------
  // carrier types and reset values
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] qcnt_m1; // queue count minus one
    logic rd_wide;       // read port 18 bits
    logic wr_wide;       // write port 18 bits
  } mqf_cfg_t;

  localparam mqf_cfg_t MQF_DEF_CFG = '{qcnt_m1: 2'h3, rd_wide: 1'b1, wr_wide: 1'b1};
  localparam logic [15:0] MQF_DEF_AFT = 16'h0008; // default almost-full distance in halves
  localparam logic [15:0] MQF_DEF_AET = 16'h0008; // default almost-empty level in halves

endpackage : mqf_pkg

// File: core/mqf_core.sv
// mqf_core: up to four fifo queues carved from one shared memory pool,
// common write port, common first-word-fall-through read port, wishbone setup.
// assumes: write and read port logic runs on clk_i; a classic wishbone master.
//
// Notes on behaviour
// - one to four queues share one pool
// - writes go to the selected write queue
// - reads come from the selected read queue
// - write and read ports act independently
// - full for write queue, valid for read
// - per-queue almost flags, user thresholds
// - two 4-bit buses show all queues
// - each port nine or eighteen bits
// - mixed widths pack halves little-endian
// - unprogrammed device uses default queue setup
// - master reset commits setup after programming
// - partial reset clears one doubly-selected queue
// - memory allocated at master reset in blocks
// - queue holds zero to all blocks
// - pool holds 64, 128 or 256 blocks
// - any 18-bit port: 512x18 block unit
// - both 9-bit ports: 1024x9 block unit
// - port widths are global for all queues
// - one write and one read per cycle
// - head word falls through without read
// - writes refused while selected queue full
// - empty queue keeps last output word
//
// Implementation choices: register access over Wishbone and the address map.

`timescale 1ns/100ps
`default_nettype none

module mqf_core #(
  parameter int BLOCKS = mqf_pkg::MQF_DEF_BLOCKS // 64, 128 or 256
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [17:0] wr_data_i,
  input wire logic [1:0] write_queue_select_i,
  input wire logic write_select_strobe_i,
  output logic queue_full_flag_o,
  output logic almost_full_flag_o,
  // read port
  input wire logic rd_en_i,
  input wire logic [1:0] read_queue_select_i,
  input wire logic read_select_strobe_i,
  output logic [17:0] rd_data_o,
  output logic output_valid_flag_o,
  output logic almost_empty_flag_o,
  // status buses
  output logic [3:0] almost_full_status_bus_o,
  output logic [3:0] almost_empty_status_bus_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ----------------------------------------------------------------------
  // sizes and types
  // ----------------------------------------------------------------------
  localparam int NQ = mqf_pkg::MQF_MAX_Q;
  localparam int BW = $clog2(BLOCKS) + 1;           // block count incl. whole pool
  localparam int LW = BW + mqf_pkg::MQF_BLK_SH;     // level/pointer in halves
  localparam int RW = LW - 2;                       // row address of a half bank
  localparam int ROWS = BLOCKS * mqf_pkg::MQF_BLK_HALVES / 2;
  typedef logic [LW-1:0] mqf_lvl_t;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // advance a queue offset, wrapping at the queue size
  function automatic mqf_lvl_t mqf_adv(input mqf_lvl_t off, input mqf_lvl_t step, input mqf_lvl_t size);
    mqf_lvl_t s;
    s = off + step;
    return (s >= size) ? '0 : s;
  endfunction : mqf_adv

  // queue size in blocks to halves
  // one block is 1024 halves in any width
  function automatic mqf_lvl_t mqf_halves(input logic [BW-1:0] blk);
    return {blk, {mqf_pkg::MQF_BLK_SH{1'b0}}};
  endfunction : mqf_halves

  // no room for one more port word
  function automatic logic mqf_full(input mqf_lvl_t lvl, input mqf_lvl_t step, input mqf_lvl_t size);
    return (lvl + step) > size;
  endfunction : mqf_full

  // byte-lane merge of a wishbone write
  function automatic logic [31:0] mqf_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : mqf_merge

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  mqf_pkg::mqf_cfg_t cfg_act_r;     // committed setup
  mqf_pkg::mqf_cfg_t cfg_stg_r;     // staged setup
  logic [BW-1:0] sz_act_r [NQ];     // committed sizes in blocks
  logic [BW-1:0] sz_stg_r [NQ];     // staged sizes
  mqf_lvl_t base_r [NQ];            // queue start in the pool
  logic [15:0] aft_r [NQ];          // almost-full distance
  logic [15:0] aet_r [NQ];          // almost-empty level
  mqf_lvl_t lvl_r [NQ];             // fill level in halves
  mqf_lvl_t wptr_r [NQ];            // write offset
  mqf_lvl_t rptr_r [NQ];            // read offset
  logic [1:0] wq_r;                 // write queue in use
  logic [1:0] rq_r;                 // read queue in use
  logic [8:0] mem_lo_r [ROWS];      // low half of each pool word
  logic [8:0] mem_hi_r [ROWS];      // high half of each pool word
  logic ack_r;
  logic [31:0] dat_r;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic wb_wr;                      // write taken this cycle
  logic [31:0] wb_rd;               // read mux
  logic [31:0] ctrl_new;            // merged control write
  logic mrst_cmd;                   // master reset command
  logic prs_cmd;                    // partial reset command
  logic [3:0] grp;
  logic [1:0] idx;

  assign grp = wb_adr_i[7:4];
  assign idx = wb_adr_i[3:2];
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && ce_i;
  assign ctrl_new = mqf_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
  assign mrst_cmd = wb_wr && grp == mqf_pkg::MQF_GRP_CTRL && idx == mqf_pkg::MQF_IDX_CTRL
                    && ctrl_new[mqf_pkg::MQF_CTRL_MRST];
  assign prs_cmd = wb_wr && grp == mqf_pkg::MQF_GRP_CTRL && idx == mqf_pkg::MQF_IDX_CTRL
                   && ctrl_new[mqf_pkg::MQF_CTRL_PRST];

  // ----------------------------------------------------------------------
  // queue arithmetic
  // ----------------------------------------------------------------------
  mqf_lvl_t wstep, rstep;           // halves moved per access
  logic wr_acc, rd_acc;             // accesses taken
  logic [1:0] wq_nxt, rq_nxt;
  mqf_lvl_t lvl_rd [NQ];            // level after reads only
  mqf_lvl_t lvl_nxt [NQ];
  mqf_lvl_t wptr_nxt [NQ];
  mqf_lvl_t rptr_nxt [NQ];
  logic [3:0] af_nxt, ae_nxt;

  // global widths, x9 or x18 per port
  assign wstep = cfg_act_r.wr_wide ? mqf_lvl_t'(2) : mqf_lvl_t'(1);
  assign rstep = cfg_act_r.rd_wide ? mqf_lvl_t'(2) : mqf_lvl_t'(1);
  assign wr_acc = wr_en_i && !queue_full_flag_o;
  assign rd_acc = rd_en_i && output_valid_flag_o;
  assign wq_nxt = write_select_strobe_i ? write_queue_select_i : wq_r;
  assign rq_nxt = read_select_strobe_i ? read_queue_select_i : rq_r;

  // per-queue next pointers and levels
  always_comb
  begin
    for (int q = 0; q < NQ; q++)
    begin
      wptr_nxt[q] = wptr_r[q];
      rptr_nxt[q] = rptr_r[q];
      lvl_rd[q] = lvl_r[q];
      if (rd_acc && rq_r == 2'(q))
      begin
        lvl_rd[q] = lvl_r[q] - rstep;
        rptr_nxt[q] = mqf_adv(rptr_r[q], rstep, mqf_halves(sz_act_r[q]));
      end
      lvl_nxt[q] = lvl_rd[q];
      if (wr_acc && wq_r == 2'(q))
      begin
        lvl_nxt[q] = lvl_rd[q] + wstep;
        wptr_nxt[q] = mqf_adv(wptr_r[q], wstep, mqf_halves(sz_act_r[q]));
      end
      if (prs_cmd && wq_r == rq_r && wq_r == 2'(q))
      begin
        lvl_rd[q] = '0;
        lvl_nxt[q] = '0;
        wptr_nxt[q] = '0;
        rptr_nxt[q] = '0;
      end
      af_nxt[q] = (sz_act_r[q] != '0) && (q <= int'(cfg_act_r.qcnt_m1))
                  && (lvl_nxt[q] + mqf_lvl_t'(aft_r[q]) >= mqf_halves(sz_act_r[q]));
      ae_nxt[q] = (sz_act_r[q] != '0) && (q <= int'(cfg_act_r.qcnt_m1))
                  && (lvl_nxt[q] <= mqf_lvl_t'(aet_r[q]));
    end
  end

  // ----------------------------------------------------------------------
  // setup registers
  // ----------------------------------------------------------------------
  // staged and committed configuration, thresholds
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_act_r <= mqf_pkg::MQF_DEF_CFG;
      cfg_stg_r <= mqf_pkg::MQF_DEF_CFG;
      for (int q = 0; q < NQ; q++)
      begin
        sz_act_r[q] <= BW'(BLOCKS / NQ);
        sz_stg_r[q] <= BW'(BLOCKS / NQ);
        base_r[q] <= mqf_halves(BW'(q * (BLOCKS / NQ)));
        aft_r[q] <= mqf_pkg::MQF_DEF_AFT;
        aet_r[q] <= mqf_pkg::MQF_DEF_AET;
      end
    end
    else if (ce_i)
    begin
      if (wb_wr && grp == mqf_pkg::MQF_GRP_CTRL && idx == mqf_pkg::MQF_IDX_CTRL)
      begin
        cfg_stg_r <= mqf_pkg::mqf_cfg_t'(mqf_merge(32'(cfg_stg_r), wb_dat_i, wb_sel_i) & 32'h0000_000f);
      end
      if (wb_wr && grp == mqf_pkg::MQF_GRP_QSIZE)
      begin
        sz_stg_r[idx] <= BW'(mqf_merge(32'(sz_stg_r[idx]), wb_dat_i, wb_sel_i));
      end
      if (wb_wr && grp == mqf_pkg::MQF_GRP_AFT)
      begin
        aft_r[idx] <= 16'(mqf_merge(32'(aft_r[idx]), wb_dat_i, wb_sel_i));
      end
      if (wb_wr && grp == mqf_pkg::MQF_GRP_AET)
      begin
        aet_r[idx] <= 16'(mqf_merge(32'(aet_r[idx]), wb_dat_i, wb_sel_i));
      end
      if (mrst_cmd)
      begin
        cfg_act_r <= cfg_stg_r;
        for (int q = 0; q < NQ; q++)
        begin
          sz_act_r[q] <= (q <= int'(cfg_stg_r.qcnt_m1)) ? sz_stg_r[q] : '0;
          base_r[q] <= '0;
          for (int p = 0; p < q; p++)
          begin
            if (p <= int'(cfg_stg_r.qcnt_m1))
            begin
              base_r[q] <= base_r[q];
            end
          end
        end
        base_r[1] <= mqf_halves(sz_stg_r[0]);
        base_r[2] <= mqf_halves(sz_stg_r[0]) + mqf_halves(sz_stg_r[1]);
        base_r[3] <= mqf_halves(sz_stg_r[0]) + mqf_halves(sz_stg_r[1]) + mqf_halves(sz_stg_r[2]);
      end
    end
  end

  // ----------------------------------------------------------------------
  // queue state
  // ----------------------------------------------------------------------
  // pointers and levels per queue
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ce_i && mrst_cmd))
    begin
      for (int q = 0; q < NQ; q++)
      begin
        lvl_r[q] <= '0;
        wptr_r[q] <= '0;
        rptr_r[q] <= '0;
      end
      wq_r <= 2'h0;
      rq_r <= 2'h0;
    end
    else if (ce_i)
    begin
      for (int q = 0; q < NQ; q++)
      begin
        lvl_r[q] <= lvl_nxt[q];
        wptr_r[q] <= wptr_nxt[q];
        rptr_r[q] <= rptr_nxt[q];
      end
      wq_r <= wq_nxt;
      rq_r <= rq_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // pool memory
  // ----------------------------------------------------------------------
  mqf_lvl_t wpa, rpa;               // physical half addresses
  assign wpa = base_r[wq_r] + wptr_r[wq_r];
  assign rpa = base_r[rq_nxt] + rptr_nxt[rq_nxt];

  // low half first, both 9-bit banks share a row
  always_ff @(posedge clk_i)
  begin
    if (ce_i && wr_acc && !rst_i)
    begin
      if (cfg_act_r.wr_wide)
      begin
        mem_lo_r[wpa[RW:1]] <= wr_data_i[8:0];
        mem_hi_r[wpa[RW:1]] <= wr_data_i[17:9];
      end
      else if (wpa[0])
      begin
        mem_hi_r[wpa[RW:1]] <= wr_data_i[8:0];
      end
      else
      begin
        mem_lo_r[wpa[RW:1]] <= wr_data_i[8:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // read output register
  // ----------------------------------------------------------------------
  // head of the queue falls through
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_data_o <= 18'h00000;
      output_valid_flag_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (mrst_cmd)
      begin
        output_valid_flag_o <= 1'b0;
      end
      // a word may follow every cycle
      else if (lvl_rd[rq_nxt] >= rstep)
      begin
        output_valid_flag_o <= 1'b1;
        rd_data_o <= cfg_act_r.rd_wide ? {mem_hi_r[rpa[RW:1]], mem_lo_r[rpa[RW:1]]}
                     : {9'h000, (rpa[0] ? mem_hi_r[rpa[RW:1]] : mem_lo_r[rpa[RW:1]])};
      end
      else
      begin
        output_valid_flag_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------------
  // selected queue flags, status buses
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ce_i && mrst_cmd))
    begin
      queue_full_flag_o <= 1'b1;
      almost_full_flag_o <= 1'b0;
      almost_empty_flag_o <= 1'b0;
      almost_full_status_bus_o <= 4'h0;
      almost_empty_status_bus_o <= 4'h0;
    end
    else if (ce_i)
    begin
      queue_full_flag_o <= mqf_full(lvl_nxt[wq_nxt], wstep, mqf_halves(sz_act_r[wq_nxt]));
      almost_full_flag_o <= af_nxt[wq_nxt];
      almost_empty_flag_o <= ae_nxt[rq_nxt];
      almost_full_status_bus_o <= af_nxt;
      almost_empty_status_bus_o <= ae_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------------
  // read mux, unmapped reads zero
  always_comb
  begin
    wb_rd = 32'h0000_0000;
    unique case (grp)
      mqf_pkg::MQF_GRP_CTRL:
      begin
        if (idx == mqf_pkg::MQF_IDX_CTRL)
        begin
          wb_rd = 32'(cfg_stg_r);
        end
        else if (idx == mqf_pkg::MQF_IDX_STAT)
        begin
          wb_rd = {12'h000, almost_empty_status_bus_o, almost_full_status_bus_o, 2'h0,
                   output_valid_flag_o, queue_full_flag_o, rq_r, wq_r, 4'(cfg_act_r)};
        end
      end
      mqf_pkg::MQF_GRP_QSIZE: wb_rd = 32'(sz_stg_r[idx]);
      mqf_pkg::MQF_GRP_AFT: wb_rd = 32'(aft_r[idx]);
      mqf_pkg::MQF_GRP_AET: wb_rd = 32'(aet_r[idx]);
      mqf_pkg::MQF_GRP_LVL: wb_rd = 32'(lvl_r[idx]);
      default: wb_rd = 32'h0000_0000;
    endcase
  end

  // one-cycle ack, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      dat_r <= wb_rd;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  mqf_lvl_t lvl_wsel, wptr_wsel;
  assign lvl_wsel = lvl_r[wq_r];
  assign wptr_wsel = wptr_r[wq_r];

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_out_idle;
    !output_valid_flag_o ##1 !output_valid_flag_o;
  endsequence
  sequence s_wr_try;
    ce_i && wr_en_i && !write_select_strobe_i && !prs_cmd && !mrst_cmd;
  endsequence

  property p_full_gate;
    (s_wr_try and queue_full_flag_o) |=> $stable(wptr_wsel);
  endproperty
  a_full_gate: assert property (p_full_gate) else $error("write taken while full");

  property p_wr_every;
    (s_wr_try and !queue_full_flag_o) |=> !$stable(wptr_wsel);
  endproperty
  a_wr_every: assert property (p_wr_every) else $error("write not taken");

  property p_full_calc;
    (ce_i && !rst_i && !mrst_cmd) |=> queue_full_flag_o == mqf_full(lvl_wsel, wstep, mqf_halves(sz_act_r[wq_r]));
  endproperty
  a_full_calc: assert property (p_full_calc) else $error("full flag wrong");

  property p_hold;
    s_out_idle |-> $stable(rd_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("output word changed while empty");

  property p_af_sel;
    almost_full_flag_o == almost_full_status_bus_o[wq_r];
  endproperty
  a_af_sel: assert property (p_af_sel) else $error("almost-full flag differs from bus");

  property p_ae_sel;
    almost_empty_flag_o == almost_empty_status_bus_o[rq_r];
  endproperty
  a_ae_sel: assert property (p_ae_sel) else $error("almost-empty flag differs from bus");

  property p_idle_q;
    (ce_i && wq_r != 2'h0 && rq_r != 2'h0 && !mrst_cmd) |=> $stable(lvl_r[0]);
  endproperty
  a_idle_q: assert property (p_idle_q) else $error("unselected queue changed");

  property p_prst;
    (ce_i && prs_cmd && wq_r == rq_r && !write_select_strobe_i && !mrst_cmd) |=> lvl_wsel == '0;
  endproperty
  a_prst: assert property (p_prst) else $error("partial reset did not clear");

  property p_default;
    @(posedge clk_i) disable iff (1'b0) rst_i |=> cfg_act_r == mqf_pkg::MQF_DEF_CFG;
  endproperty
  a_default: assert property (p_default) else $error("reset setup not default");

endmodule : mqf_core

`default_nettype wire

// File: testbench/mqf_reader_model.sv
// mqf_reader_model: downstream reader that consumes words with random stalls
// assumes: the bench seeds $urandom once and raises go_i to let it read
`timescale 1ns/100ps
`default_nettype none
module mqf_reader_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control and read enable
  input wire logic go_i,
  output var logic rd_en_o
);
  always @(posedge clk_i)
  begin
    if (rst_i)
      rd_en_o <= 1'b0;
    else
      rd_en_o <= go_i & (($urandom % 4) != 0);
  end
endmodule : mqf_reader_model
`default_nettype wire

// File: testbench/multi_queue_fifo_core_tb.sv
// multi_queue_fifo_core_tb: self-checking bench for mqf_core with a small pool
// assumes: mqf_reader_model on the read port, bench acts as writer and wb master
`timescale 1ns/100ps
`default_nettype none
module multi_queue_fifo_core_tb;
  logic clk_i = 0, rst_i = 1, wr_en = 0, wstb = 0, rstb = 0, go = 0, cyc = 0, stb = 0, we = 0;
  logic [17:0] wdat = '0, last;
  logic [1:0] wq = 0, rq = 0;
  logic [7:0] adr = 0;
  logic [31:0] wdo = 0, r;
  wire logic full, af, ov, ae, ack, rd_en;
  wire logic [17:0] rdata;
  wire logic [3:0] afb, aeb;
  wire logic [31:0] wbo;
  int error_cnt = 0, total_checks = 0, got = 0;
  logic [17:0] exp_q [4][$]; // expected words per queue
  initial forever #20 clk_i = ~clk_i;
  mqf_core #(.BLOCKS(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wr_en_i(wr_en), .wr_data_i(wdat),
    .write_queue_select_i(wq), .write_select_strobe_i(wstb), .queue_full_flag_o(full), .almost_full_flag_o(af),
    .rd_en_i(rd_en), .read_queue_select_i(rq), .read_select_strobe_i(rstb), .rd_data_o(rdata),
    .output_valid_flag_o(ov), .almost_empty_flag_o(ae), .almost_full_status_bus_o(afb),
    .almost_empty_status_bus_o(aeb), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdo), .wb_dat_o(wbo), .wb_ack_o(ack));
  mqf_reader_model rdm_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .rd_en_o(rd_en));
  // compare one value and count it
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
  begin
    total_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  end
  endtask : chk
  // print counts and verdict, end the run
  task results();
  begin
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask : results
  // classic wishbone single cycle, held until ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
  begin
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdo <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin error_cnt++; results(); end
    rd = wbo;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk_i);
  end
  endtask : wb
  // one write cycle, noting the word if it must be stored
  task wr(input logic [1:0] q, input logic [17:0] d, input bit p);
  begin
    if (p) exp_q[q].push_back(d);
    wr_en <= 1; wdat <= d;
    @(posedge clk_i);
  end
  endtask : wr
  // latch a queue select on one port, let flags settle
  task sel(input bit w, input logic [1:0] q);
  begin
    wr_en <= 0;
    if (w) begin wq <= q; wstb <= 1; end else begin rq <= q; rstb <= 1; end
    @(posedge clk_i);
    wstb <= 0; rstb <= 0;
    repeat (2) @(posedge clk_i);
  end
  endtask : sel
  // let the reader consume n more words
  task drain(input int n);
    int t;
  begin
    t = 0; n = got + n; go <= 1;
    while (got < n && t < 5000) begin @(posedge clk_i); t++; end
    if (t >= 5000) begin error_cnt++; results(); end
    go <= 0;
    repeat (3) @(posedge clk_i);
  end
  endtask : drain
  // scoreboard: compare each consumed word with the oldest note
  always @(posedge clk_i)
  begin
    if (!rst_i && rd_en === 1'b1 && ov === 1'b1)
    begin
      last = exp_q[rq].pop_front();
      chk("rd_data", 32'(rdata), 32'(last));
      got++;
    end
  end
  initial begin #400000; error_cnt++; results(); end
  initial
  begin
    void'($urandom(10));
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    repeat (2) @(posedge clk_i);
    chk("full", 32'(full), 0);
    wb(0, 8'h04, 0, r); chk("status cfg", r[3:0], 4'hf);
    wb(0, 8'h10, 0, r); chk("qsize", r, 1);
    wb(0, 8'h80, 0, r); chk("unmapped", r, 0);
    $display("test reset done");
    for (int q = 0; q < 4; q++) begin sel(1, 2'(q)); repeat (3) wr(2'(q), {q[1:0], 16'($urandom)}, 1); end
    sel(1, 0);
    chk("ae bus", 32'(aeb), 4'hf);
    for (int q = 0; q < 4; q++) begin sel(0, 2'(q)); chk("ov head", 32'(ov), 1); drain(3); end
    $display("test steering done");
    for (int i = 0; i < 513; i++) wr(0, 18'($urandom), i < 512);
    sel(1, 0);
    chk("full", 32'(full), 1);
    chk("af bus", 32'(afb), 4'h1);
    wb(0, 8'h40, 0, r); chk("level", r, 32'h400);
    sel(0, 0); drain(512);
    chk("full drop", 32'(full), 0);
    sel(0, 3); chk("ov empty", 32'(ov), 0); chk("hold", 32'(rdata), 32'(last));
    $display("test fill done");
    sel(1, 1); sel(0, 1); wr(1, 18'h1, 0); wr(1, 18'h2, 0);
    wr_en <= 0;
    wb(1, 8'h00, 32'h20f, r);
    wb(0, 8'h44, 0, r); chk("prst level", r, 0);
    chk("prst ov", 32'(ov), 0);
    $display("test partial reset done");
    wb(1, 8'h00, 32'h00e, r); wb(1, 8'h00, 32'h10e, r);
    wb(0, 8'h04, 0, r); chk("status cfg", r[3:0], 4'he);
    sel(1, 2); r = $urandom; wr(2, {9'h0, r[8:0]}, 0); wr(2, {9'h0, r[17:9]}, 0);
    exp_q[2].push_back(r[17:0]); sel(0, 2); drain(1);
    wb(1, 8'h00, 32'h00d, r); wb(1, 8'h00, 32'h10d, r); sel(1, 3); wr(3, 18'h2a5b3, 0);
    exp_q[3].push_back(18'h1b3); exp_q[3].push_back(18'h152); sel(0, 3); drain(2);
    wb(1, 8'h00, 32'h003, r); wb(1, 8'h00, 32'h103, r); sel(1, 0);
    chk("one queue ae", 32'(aeb), 4'h1);
    $display("test widths done");
    results();
  end
endmodule : multi_queue_fifo_core_tb
`default_nettype wire
